// ---- logic/fspc_pkg.sv ----
// Constants and carrier types for the flash self-program controller.
// Assumes a single 250 MHz clock and an Avalon-MM slave with word addresses.
// Operation
// - Data pair holds a 14-bit program word for reads and programming.
// - Address pair holds a 9-bit program memory address.
// - Program and erase duration is timed by an internal counter.
// - Code lock blocks external programmer access, not self-write or erase.
// - Code lock is released only by an external bulk erase of everything.
// - Self-program-protect field blocks self erase/program of its region.
// - Up to 512 words; high register holds MSB, low register LSB.
// - Software sets read and program strobes; hardware clears them on finish.
// - Program or erase only while permit bit set; permit clear at power-up.
// - Abort flag set when reset interrupts a program or erase.
// - Unlock key register is write-only and reads as zero.
// - No latch load or programming without the received key pattern.
// - Memory is organised in rows; erase acts on a whole row.
// - 14-bit write latches, loaded only through the data pair.
// - One write latch per row word, 16 words per row.
// - Array read in second cycle after strobe, word shown the next cycle.
// - Read word stays in data pair until another read or software write.
// - Program and erase use internal high voltage, no external supply.
// - Key 55h then aah then program strobe, uninterrupted, else nothing starts.
// - Row erase or program stalls the cpu about 2 ms, clocks keep running.
// - All write latches return to 3fffh after every program or erase.
// - Latch-only-load set loads one latch; clear programs the whole row.
package fspc_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 14;
  localparam int ROW_WORDS = 16;
  localparam int ROW_W = 4;
  // Register word indices on the bus
  localparam logic [2:0] OFS_ADDR_LOW = 3'h0;
  localparam logic [2:0] OFS_ADDR_HIGH = 3'h1;
  localparam logic [2:0] OFS_WORD_LOW = 3'h2;
  localparam logic [2:0] OFS_WORD_HIGH = 3'h3;
  localparam logic [2:0] OFS_CTRL = 3'h4;
  localparam logic [2:0] OFS_KEY = 3'h5;
  // Control register bit positions
  localparam int B_RD = 0;
  localparam int B_WR = 1;
  localparam int B_PERMIT = 2;
  localparam int B_ABORT = 3;
  localparam int B_FREE = 4;
  localparam int B_LATCH_ONLY_LOAD = 5;
  localparam int B_CONFIG_SPACE_SELECT = 6;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3fff;
  localparam int CLK_MHZ = 250;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int READ_DELAY = 2;
  localparam logic [1:0] BUS_WAIT = 2'h1;

  typedef enum logic [2:0] {
    FSPC_IDLE = 3'b000,
    FSPC_READ = 3'b001,
    FSPC_ERASE = 3'b010,
    FSPC_PROG = 3'b011,
    FSPC_LATCH = 3'b100
  } fspc_state_t;

  typedef enum logic [1:0] {
    FSPC_KEY_NONE = 2'b00,
    FSPC_KEY_HALF = 2'b01,
    FSPC_KEY_FULL = 2'b10
  } fspc_key_t;

  // Array port toward the flash macro
  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fspc_array_req_t;
endpackage

// ---- logic/fspc_ctrl.sv ----
// Flash self-program controller: registers, unlock key, latches, sequencer.
// Assumes a flash array answering reads in the same cycle as rd.
`timescale 1ns/10ps
module fspc_ctrl #(
  parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES,
  parameter int ROW_WORDS = fspc_pkg::ROW_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic por_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] self_program_protect_i,
  input wire logic code_lock_n_i,
  input wire logic ext_access_req_i,
  output logic ext_access_ok_o,
  output logic cpu_stall_o,
  output fspc_pkg::fspc_array_req_t array_req_o,
  input wire logic [fspc_pkg::DATA_W-1:0] array_rdata_i
);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  logic [7:0] prog_addr_low;
  logic [7:0] prog_addr_high;
  logic [7:0] prog_word_low;
  logic [7:0] prog_word_high;
  logic [7:0] flash_ctrl_reg;
  fspc_pkg::fspc_key_t key_reg;
  fspc_pkg::fspc_state_t state_reg;
  fspc_pkg::fspc_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [1:0] bus_cnt_reg;
  logic [fspc_pkg::DATA_W-1:0] latch_reg [ROW_WORDS];
  logic [fspc_pkg::ADDR_W-1:0] addr;
  logic [fspc_pkg::ROW_W-1:0] lidx;
  logic [fspc_pkg::ROW_W-1:0] prog_idx_reg;
  logic acc;
  logic wr_ctrl;
  logic wr_start;
  logic protected_row;
  logic op_done;

  assign addr = {prog_addr_high[0], prog_addr_low};
  assign lidx = prog_addr_low[fspc_pkg::ROW_W-1:0];
  // One wait cycle per access keeps timing simple for software
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) && (bus_cnt_reg != fspc_pkg::BUS_WAIT);
  assign acc = (avs_read_i | avs_write_i) && !avs_waitrequest_o;
  assign wr_ctrl = acc && avs_write_i && avs_address_i == fspc_pkg::OFS_CTRL;
  // Protect code 0 guards all, 1 the top half, 2 the top quarter, 3 nothing
  always_comb begin
    case (self_program_protect_i)
      2'h0: protected_row = 1'b1;
      2'h1: protected_row = addr[fspc_pkg::ADDR_W-1];
      2'h2: protected_row = addr[fspc_pkg::ADDR_W-1] & addr[fspc_pkg::ADDR_W-2];
      default: protected_row = 1'b0;
    endcase
  end
  // Start only with permit, full key, idle, and row not protected
  assign wr_start = wr_ctrl && avs_writedata_i[fspc_pkg::B_WR] && state_reg == fspc_pkg::FSPC_IDLE
    && flash_ctrl_reg[fspc_pkg::B_PERMIT] && key_reg == fspc_pkg::FSPC_KEY_FULL
    && !flash_ctrl_reg[fspc_pkg::B_CONFIG_SPACE_SELECT] && !protected_row;
  assign op_done = cnt_reg == '0;

  // Count restarts after every taken access, so back-to-back requests also wait once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || acc || !(avs_read_i | avs_write_i)) begin
      bus_cnt_reg <= 2'h0;
    end else begin
      bus_cnt_reg <= bus_cnt_reg + 2'h1;
    end
  end

  // Unlock key tracker: any other access breaks the sequence
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      key_reg <= fspc_pkg::FSPC_KEY_NONE;
    end else if (acc) begin
      if (avs_write_i && avs_address_i == fspc_pkg::OFS_KEY) begin
        if (avs_writedata_i[7:0] == fspc_pkg::KEY_FIRST) begin
          key_reg <= fspc_pkg::FSPC_KEY_HALF;
        end else if (avs_writedata_i[7:0] == fspc_pkg::KEY_SECOND && key_reg == fspc_pkg::FSPC_KEY_HALF) begin
          key_reg <= fspc_pkg::FSPC_KEY_FULL;
        end else begin
          key_reg <= fspc_pkg::FSPC_KEY_NONE;
        end
      end else begin
        key_reg <= fspc_pkg::FSPC_KEY_NONE;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fspc_pkg::FSPC_IDLE: begin
        if (wr_start) begin
          if (flash_ctrl_reg[fspc_pkg::B_FREE]) begin
            state_next = fspc_pkg::FSPC_ERASE;
          end else if (flash_ctrl_reg[fspc_pkg::B_LATCH_ONLY_LOAD]) begin
            state_next = fspc_pkg::FSPC_LATCH;
          end else begin
            state_next = fspc_pkg::FSPC_PROG;
          end
        end else if (wr_ctrl && avs_writedata_i[fspc_pkg::B_RD]) begin
          state_next = fspc_pkg::FSPC_READ;
        end
      end
      fspc_pkg::FSPC_READ: if (op_done) state_next = fspc_pkg::FSPC_IDLE;
      fspc_pkg::FSPC_ERASE: if (op_done) state_next = fspc_pkg::FSPC_IDLE;
      fspc_pkg::FSPC_PROG: if (op_done) state_next = fspc_pkg::FSPC_IDLE;
      fspc_pkg::FSPC_LATCH: state_next = fspc_pkg::FSPC_IDLE;
      default: state_next = fspc_pkg::FSPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= fspc_pkg::FSPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Internal timer: erase and program duration set in hardware
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (state_reg == fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_READ) begin
      cnt_reg <= CW'(fspc_pkg::READ_DELAY - 1);
    end else if (state_reg == fspc_pkg::FSPC_IDLE && (state_next == fspc_pkg::FSPC_ERASE
        || state_next == fspc_pkg::FSPC_PROG)) begin
      cnt_reg <= CW'(PROG_CYCLES - 1);
    end else if (!op_done) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end

  // Row program walks the latches one per cycle at the start of the timer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_reg != fspc_pkg::FSPC_PROG) begin
      prog_idx_reg <= '0;
    end else if (prog_idx_reg != fspc_pkg::ROW_W'(ROW_WORDS - 1)) begin
      prog_idx_reg <= prog_idx_reg + fspc_pkg::ROW_W'(1);
    end
  end

  always_comb begin
    array_req_o = '0;
    array_req_o.addr = addr;
    array_req_o.rd = state_reg == fspc_pkg::FSPC_READ && cnt_reg == '0;
    array_req_o.erase = state_reg == fspc_pkg::FSPC_ERASE;
    if (state_reg == fspc_pkg::FSPC_PROG) begin
      array_req_o.prog = 1'b1;
      array_req_o.addr = {addr[fspc_pkg::ADDR_W-1:fspc_pkg::ROW_W], prog_idx_reg};
      array_req_o.wdata = latch_reg[prog_idx_reg];
    end
  end
  assign cpu_stall_o = state_reg == fspc_pkg::FSPC_ERASE || state_reg == fspc_pkg::FSPC_PROG;
  // Programmer request comes from a pin; two flops guard against metastability
  logic ext_req_meta_reg;
  logic ext_req_sync_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_req_meta_reg <= 1'b0;
      ext_req_sync_reg <= 1'b0;
    end else begin
      ext_req_meta_reg <= ext_access_req_i;
      ext_req_sync_reg <= ext_req_meta_reg;
    end
  end
  assign ext_access_ok_o = ext_req_sync_reg & code_lock_n_i;

  // Write latches, blank after every erase or program
  generate
    for (genvar i = 0; i < ROW_WORDS; i++) begin : g_latch
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          latch_reg[i] <= fspc_pkg::BLANK_WORD;
        end else if ((state_reg == fspc_pkg::FSPC_ERASE || state_reg == fspc_pkg::FSPC_PROG)
            && op_done) begin
          latch_reg[i] <= fspc_pkg::BLANK_WORD;
        end else if (state_reg == fspc_pkg::FSPC_IDLE && state_next != fspc_pkg::FSPC_IDLE
            && state_next != fspc_pkg::FSPC_READ && lidx == fspc_pkg::ROW_W'(i)
            && state_next != fspc_pkg::FSPC_ERASE) begin
          latch_reg[i] <= {prog_word_high[5:0], prog_word_low};
        end
      end
    end
  endgenerate

  // Address and data pairs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_addr_low <= 8'h00;
      prog_addr_high <= 8'h00;
    end else if (acc && avs_write_i && avs_address_i == fspc_pkg::OFS_ADDR_LOW) begin
      prog_addr_low <= avs_writedata_i[7:0];
    end else if (acc && avs_write_i && avs_address_i == fspc_pkg::OFS_ADDR_HIGH) begin
      prog_addr_high <= {7'h00, avs_writedata_i[0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_word_low <= 8'h00;
      prog_word_high <= 8'h00;
    end else if (array_req_o.rd) begin
      prog_word_low <= array_rdata_i[7:0];
      prog_word_high <= {2'h0, array_rdata_i[13:8]};
    end else if (acc && avs_write_i && avs_address_i == fspc_pkg::OFS_WORD_LOW) begin
      prog_word_low <= avs_writedata_i[7:0];
    end else if (acc && avs_write_i && avs_address_i == fspc_pkg::OFS_WORD_HIGH) begin
      prog_word_high <= {2'h0, avs_writedata_i[5:0]};
    end
  end

  // Control register; permit cleared at power-up, abort set by reset mid-operation
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      flash_ctrl_reg <= 8'h00;
    end else if (!rst_n_i) begin
      flash_ctrl_reg[fspc_pkg::B_RD] <= 1'b0;
      flash_ctrl_reg[fspc_pkg::B_WR] <= 1'b0;
      if (cpu_stall_o) begin
        flash_ctrl_reg[fspc_pkg::B_ABORT] <= 1'b1;
      end
    end else begin
      if (wr_ctrl) begin
        flash_ctrl_reg[fspc_pkg::B_PERMIT] <= avs_writedata_i[fspc_pkg::B_PERMIT];
        flash_ctrl_reg[fspc_pkg::B_ABORT] <= avs_writedata_i[fspc_pkg::B_ABORT];
        flash_ctrl_reg[fspc_pkg::B_FREE] <= avs_writedata_i[fspc_pkg::B_FREE];
        flash_ctrl_reg[fspc_pkg::B_LATCH_ONLY_LOAD] <= avs_writedata_i[fspc_pkg::B_LATCH_ONLY_LOAD];
        flash_ctrl_reg[fspc_pkg::B_CONFIG_SPACE_SELECT] <= avs_writedata_i[fspc_pkg::B_CONFIG_SPACE_SELECT];
      end
      // Strobes only set by software, cleared by hardware at finish
      flash_ctrl_reg[fspc_pkg::B_RD] <= (flash_ctrl_reg[fspc_pkg::B_RD]
        || state_next == fspc_pkg::FSPC_READ) && state_next != fspc_pkg::FSPC_IDLE;
      flash_ctrl_reg[fspc_pkg::B_WR] <= state_next == fspc_pkg::FSPC_ERASE
        || state_next == fspc_pkg::FSPC_PROG || state_next == fspc_pkg::FSPC_LATCH;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i) begin
      case (avs_address_i)
        fspc_pkg::OFS_ADDR_LOW: avs_readdata_o <= {24'h0, prog_addr_low};
        fspc_pkg::OFS_ADDR_HIGH: avs_readdata_o <= {24'h0, prog_addr_high};
        fspc_pkg::OFS_WORD_LOW: avs_readdata_o <= {24'h0, prog_word_low};
        fspc_pkg::OFS_WORD_HIGH: avs_readdata_o <= {24'h0, prog_word_high};
        fspc_pkg::OFS_CTRL: avs_readdata_o <= {24'h0, flash_ctrl_reg};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  a_strobe_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg != fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_IDLE)
    |=> !flash_ctrl_reg[fspc_pkg::B_RD] && !flash_ctrl_reg[fspc_pkg::B_WR])
    else $error("strobe not cleared at finish");
  a_permit_needed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_PROG)
    |-> flash_ctrl_reg[fspc_pkg::B_PERMIT])
    else $error("program without permit");
  a_key_needed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(cpu_stall_o) |-> $past(key_reg) == fspc_pkg::FSPC_KEY_FULL)
    else $error("operation without key");
  sequence s_read_go;
    state_reg == fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_READ;
  endsequence
  a_read_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_read_go |=> !array_req_o.rd ##1 array_req_o.rd)
    else $error("read access not in second cycle");
  a_latch_blank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cpu_stall_o && op_done) |=> latch_reg[0] == fspc_pkg::BLANK_WORD)
    else $error("latches not blank after operation");
  a_protect_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == fspc_pkg::FSPC_IDLE && protected_row) |=> !cpu_stall_o)
    else $error("protected row modified");
  a_key_reads_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (avs_read_i && avs_address_i == fspc_pkg::OFS_KEY) |=> avs_readdata_o == 32'h0)
    else $error("key register readable");
  a_stall_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(cpu_stall_o) |-> cpu_stall_o [*8])
    else $error("stall too short");

  // Helper for the duration check: stalled cycles of the running operation
  localparam int SW = CW + 1;
  logic [SW-1:0] stall_len_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !cpu_stall_o) begin
      stall_len_reg <= '0;
    end else begin
      stall_len_reg <= stall_len_reg + SW'(1);
    end
  end

  sequence s_latch_go;
    state_reg == fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_LATCH;
  endsequence
  sequence s_erase_go;
    state_reg == fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_ERASE;
  endsequence
  sequence s_prog_go;
    state_reg == fspc_pkg::FSPC_IDLE && state_next == fspc_pkg::FSPC_PROG;
  endsequence

  a_stall_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(cpu_stall_o) |-> stall_len_reg == SW'(PROG_CYCLES))
    else $error("operation time not set by internal timer");
  a_abort_set: assert property (@(posedge clk_i)
    (!rst_n_i && !por_i && cpu_stall_o) |=> flash_ctrl_reg[fspc_pkg::B_ABORT])
    else $error("abort flag not set by reset");
  a_por_clear: assert property (@(posedge clk_i)
    por_i |=> flash_ctrl_reg == 8'h00)
    else $error("control not cleared at power-up");
  a_ext_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !code_lock_n_i |-> !ext_access_ok_o)
    else $error("external access while locked");
  a_ext_allowed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ext_req_sync_reg && code_lock_n_i) |-> ext_access_ok_o)
    else $error("external access refused while unlocked");
  a_read_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    array_req_o.rd |=> {prog_word_high[5:0], prog_word_low} == $past(array_rdata_i))
    else $error("read word not presented");
  a_word_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!array_req_o.rd && !(acc && avs_write_i && (avs_address_i == fspc_pkg::OFS_WORD_LOW
      || avs_address_i == fspc_pkg::OFS_WORD_HIGH)))
    |=> $stable(prog_word_low) && $stable(prog_word_high))
    else $error("data pair changed without cause");
  a_latch_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_latch_go |=> latch_reg[lidx] == $past({prog_word_high[5:0], prog_word_low}))
    else $error("latch not loaded");
  a_no_key_op: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == fspc_pkg::FSPC_IDLE && key_reg != fspc_pkg::FSPC_KEY_FULL)
    |=> !cpu_stall_o)
    else $error("operation started without unlock");
  a_erase_whole: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_erase_go |=> array_req_o.erase [*8])
    else $error("row erase cut short");
  a_prog_walk: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_prog_go |=> (array_req_o.prog && prog_idx_reg == '0)
      ##1 prog_idx_reg == fspc_pkg::ROW_W'(1))
    else $error("row program does not walk latches");
endmodule // fspc_ctrl

// ---- bench/fspc_array_model.sv ----
// Behavioural flash array on the far side of the controller's array port.
// Assumes one clock; read data is sampled in the cycle rd is high.
`timescale 1ns/10ps
module fspc_array_model (
  input wire logic clk_i,
  input wire fspc_pkg::fspc_array_req_t req_i,
  output logic [fspc_pkg::DATA_W-1:0] rdata_o
);
  logic [13:0] mem [512];
  logic [13:0] last_reg;
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 14'(i * 13) ^ 14'h2a5a;
    end
    last_reg = 14'h0;
  end
  // Outside a read the bus shows inverted old data, so a stale sample cannot pass
  assign rdata_o = req_i.rd ? mem[req_i.addr] : ~last_reg;
  always @(posedge clk_i) begin
    if (req_i.rd) begin
      last_reg <= mem[req_i.addr];
    end
    if (req_i.erase) begin
      for (int k = 0; k < 16; k++) begin
        mem[{req_i.addr[8:4], 4'(k)}] <= 14'h3fff;
      end
    end
    // Programming only clears bits, as real flash cells do
    if (req_i.prog) begin
      mem[req_i.addr] <= mem[req_i.addr] & req_i.wdata;
    end
  end
endmodule // fspc_array_model

// ---- bench/flash_self_program_ctrl_tb.sv ----
// Self-checking bench for the flash self-program controller.
// Assumes the array model beside it and a short program time.
`timescale 1ns/10ps
module flash_self_program_ctrl_tb;
  localparam int PC = 20;
  localparam logic [2:0] AL = fspc_pkg::OFS_ADDR_LOW;
  localparam logic [2:0] AH = fspc_pkg::OFS_ADDR_HIGH;
  localparam logic [2:0] WL = fspc_pkg::OFS_WORD_LOW;
  localparam logic [2:0] WH = fspc_pkg::OFS_WORD_HIGH;
  localparam logic [2:0] CT = fspc_pkg::OFS_CTRL;
  localparam logic [2:0] KY = fspc_pkg::OFS_KEY;
  logic clk_i, rst_n_i, por_i, avs_read_i, avs_write_i, code_lock_n_i, ext_access_req_i;
  logic avs_waitrequest_o, ext_access_ok_o, cpu_stall_o;
  logic [2:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, v, u;
  logic [1:0] self_program_protect_i;
  fspc_pkg::fspc_array_req_t array_req_o;
  logic [13:0] array_rdata_i, w, d;
  logic [15:0] lfsr;
  logic [8:0] a;
  int err_total, samples_checked, stall_cnt;
  fspc_ctrl #(.PROG_CYCLES(PC), .ROW_WORDS(16)) fspc_ctrl_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .por_i(por_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .self_program_protect_i(self_program_protect_i), .code_lock_n_i(code_lock_n_i),
    .ext_access_req_i(ext_access_req_i), .ext_access_ok_o(ext_access_ok_o),
    .cpu_stall_o(cpu_stall_o), .array_req_o(array_req_o), .array_rdata_i(array_rdata_i));
  fspc_array_model fspc_array_model_inst (
    .clk_i(clk_i), .req_i(array_req_o), .rdata_o(array_rdata_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (cpu_stall_o === 1'b1) begin
      stall_cnt <= stall_cnt + 1;
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [13:0] init_word(input logic [8:0] adr);
    return 14'(adr * 13) ^ 14'h2a5a;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request holds until the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] ad, input logic [7:0] dt,
                     output logic [31:0] q);
    int n;
    logic wt;
    n = 0;
    wt = 1'b1;
    avs_address_i <= ad;
    avs_writedata_i <= {24'h0, dt};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    while (wt !== 1'b0) begin
      @(posedge clk_i);
      wt = avs_waitrequest_o;
      q = avs_readdata_o;
      n++;
      if (n >= 100) begin
        err_total++;
        give_verdict;
      end
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
    logic [31:0] q;
    bus(1'b1, ad, dt, q);
  endtask
  task automatic rd(input logic [2:0] ad, output logic [31:0] q);
    bus(1'b0, ad, 8'h00, q);
  endtask
  task automatic poll(input int b);
    for (int n = 0; n < 100; n++) begin
      rd(CT, v);
      if (v[b] === 1'b0) break;
    end
    check(32'(v[b]), 32'h0);
  endtask
  task automatic set_addr(input logic [8:0] ad);
    wr(AL, ad[7:0]);
    wr(AH, {7'h0, ad[8]});
  endtask
  task automatic read_word(input logic [8:0] ad, output logic [13:0] q);
    set_addr(ad);
    wr(CT, 8'h01);
    poll(0);
    rd(WL, u);
    rd(WH, v);
    q = {v[5:0], u[7:0]};
  endtask
  task automatic unlock_go(input logic [7:0] c);
    stall_cnt = 0;
    wr(CT, c);
    wr(KY, 8'h55);
    wr(KY, 8'haa);
    wr(CT, c | 8'h02);
    poll(1);
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    give_verdict;
  end
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, ext_access_req_i, avs_address_i} = '0;
    {por_i, code_lock_n_i} = 2'h3;
    avs_writedata_i = 32'h0;
    self_program_protect_i = 2'h3;
    {err_total, samples_checked, stall_cnt} = '0;
    lfsr = 16'ha69d;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    por_i <= 1'b0;
    @(posedge clk_i);
    rd(CT, v);
    check(v, 32'h0);
    wr(KY, 8'h55);
    rd(KY, v);
    check(v, 32'h0);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : lfsr[8:0];
      wr(WL, lfsr[7:0]);
      wr(WH, lfsr[15:8]);
      rd(WL, u);
      rd(WH, v);
      check({18'h0, v[5:0], u[7:0]}, {18'h0, lfsr[13:0]});
      read_word(a, w);
      check(w, init_word(a));
      rd(AH, v);
      check(v & 32'h1, {31'h0, a[8]});
      rd(WL, u);
      check(u & 32'hff, {24'h0, init_word(a)[7:0]});
    end
    for (int i = 0; i < 4; i++) begin
      code_lock_n_i <= i[0];
      ext_access_req_i <= i[1];
      repeat (3) @(posedge clk_i);
      check(32'(ext_access_ok_o), 32'(i[0] & i[1]));
    end
    set_addr(9'h025);
    unlock_go(8'h10);
    check(stall_cnt, 0);
    wr(CT, 8'h14);
    wr(KY, 8'h55);
    rd(CT, v);
    wr(KY, 8'haa);
    wr(CT, 8'h16);
    poll(1);
    check(stall_cnt, 0);
    self_program_protect_i <= 2'h0;
    unlock_go(8'h14);
    check(stall_cnt, 0);
    self_program_protect_i <= 2'h3;
    read_word(9'h025, w);
    check(w, init_word(9'h025));
    set_addr(9'h025);
    unlock_go(8'h14);
    check(stall_cnt, PC);
    read_word(9'h02f, w);
    check(w, 14'h3fff);
    read_word(9'h030, w);
    check(w, init_word(9'h030));
    lfsr = lfsr_next(lfsr);
    d = lfsr[13:0];
    set_addr(9'h021);
    wr(WL, d[7:0]);
    wr(WH, {2'h0, d[13:8]});
    unlock_go(8'h24);
    check(stall_cnt, 0);
    set_addr(9'h02e);
    wr(WL, 8'h5a);
    wr(WH, 8'h12);
    unlock_go(8'h04);
    check(stall_cnt, PC);
    read_word(9'h021, w);
    check(w, d);
    read_word(9'h02e, w);
    check(w, 14'h125a);
    read_word(9'h022, w);
    check(w, 14'h3fff);
    set_addr(9'h040);
    wr(CT, 8'h14);
    wr(KY, 8'h55);
    wr(KY, 8'haa);
    wr(CT, 8'h16);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(CT, v);
    check(32'(v[3]), 32'h1);
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    @(posedge clk_i);
    rd(CT, v);
    check(v, 32'h0);
    give_verdict;
  end
endmodule // flash_self_program_ctrl_tb
